// ==== common/sab_pkg.sv ====
`default_nettype none
package sab_pkg;
  // ==========================================================
  // converter geometry
  localparam int RES_W      = 12;
  localparam int SHORT_BITS = 8;
  localparam int NIB_W      = 4;

  // ==========================================================
  // timing: conversion time spread over the full bit count
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 15000;
  // longest time, so rounded down by integer division
  localparam int BIT_CYCLES    = CONV_TIME_NS / (RES_W * CLK_PERIOD_NS);

  // ==========================================================
  // register map (byte addresses, decoded on haddr[7:0])
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;

  localparam int CTRL_STANDALONE_BIT = 0;
  localparam int STATUS_BUSY_BIT     = 0;
  localparam int STATUS_SHORT_BIT    = 1;
  localparam logic CTRL_STANDALONE_RST = 1'b0;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================
  // conversion sequencer
  typedef enum logic [1:0] {
    SAB_IDLE = 2'b01,
    SAB_CONV = 2'b10
  } sab_state_t;
endpackage
`default_nettype wire

// ==== rtl/sab_ctrl.sv ====
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module sab_ctrl #(
  parameter int BIT_CYCLES = sab_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // converter control pins
  input  wire logic        chip_enable,
  input  wire logic        chip_select_n,
  input  wire logic        read_convert,
  input  wire logic        byte_addr_short_cycle,
  input  wire logic        word_width_sel,
  // result pins, each group with its output enable
  output logic      [3:0]  upper_nibble_out,
  output logic             upper_nibble_oe,
  output logic      [3:0]  middle_nibble_out,
  output logic             middle_nibble_oe,
  output logic      [3:0]  lower_nibble_out,
  output logic             lower_nibble_oe,
  output logic             conversion_busy_flag,
  // successive-approximation front end
  output logic      [11:0] dac_trial,
  input  wire logic        comp_above
);

  localparam int RW = sab_pkg::RES_W;
  localparam int NW = sab_pkg::NIB_W;
  localparam logic [3:0] LAST_FULL  = 4'h0;
  localparam logic [3:0] LAST_SHORT = 4'(RW - sab_pkg::SHORT_BITS);
  localparam logic [3:0] TOP_BIT    = 4'(RW - 1);
  localparam logic [15:0] CNT_LAST  = 16'(BIT_CYCLES - 1);
  localparam sab_pkg::sab_state_t SAB_IDLE = sab_pkg::SAB_IDLE;
  localparam sab_pkg::sab_state_t SAB_CONV = sab_pkg::SAB_CONV;

  // ==========================================================
  // elaboration checks
  if (BIT_CYCLES < 1 || BIT_CYCLES * RW > 65535)
  begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  // ==========================================================
  // command decode
  sab_pkg::sab_state_t state_q;
  logic        standalone_q;
  logic        rc_prev_q;
  logic        conv_lvl_q;
  logic        short_q;
  logic        selected;
  logic        conv_lvl;
  logic        start;
  logic        rd;

  // enable high and select low both needed for any command
  assign selected = chip_enable && !chip_select_n;
  assign conv_lvl = selected && !read_convert;
  // full control acts on the start level's leading edge, so a held
  // convert level does not retrigger after completion
  always_comb
  begin
    if (standalone_q)
      start = selected && rc_prev_q && !read_convert;
    else
      start = conv_lvl && !conv_lvl_q;
    start = start && (state_q == SAB_IDLE);
  end
  // result is not available while converting
  assign rd = selected && read_convert && (state_q == SAB_IDLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rc_prev_q  <= 1'b1;
      conv_lvl_q <= 1'b0;
    end
    else
    begin
      rc_prev_q  <= read_convert;
      conv_lvl_q <= conv_lvl;
    end
  end

  // ==========================================================
  // successive-approximation sequencer
  logic [11:0] trial_q;
  logic [11:0] decided;
  logic [11:0] res_q;
  logic [3:0]  bit_q;
  logic [15:0] cnt_q;
  logic        bit_end;
  logic        last_bit;
  assign bit_end  = (cnt_q == CNT_LAST);
  assign last_bit = (bit_q == (short_q ? LAST_SHORT : LAST_FULL));
  always_comb
  begin
    decided = trial_q;
    decided[bit_q] = comp_above;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= SAB_IDLE;
      trial_q <= 12'h000;
      res_q   <= 12'h000;
      bit_q   <= 4'h0;
      cnt_q   <= 16'h0000;
      short_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        SAB_IDLE:
        begin
          if (start)
          begin
            state_q <= SAB_CONV;
            // address level at start picks the cycle length
            short_q <= byte_addr_short_cycle;
            trial_q <= 12'h800;
            bit_q   <= TOP_BIT;
            cnt_q   <= 16'h0000;
          end
        end
        SAB_CONV:
        begin
          if (!bit_end)
            cnt_q <= cnt_q + 16'h0001;
          else
          begin
            cnt_q <= 16'h0000;
            if (last_bit)
            begin
              // msb first, code read as fraction of full scale;
              // bipolar offset comes out as offset binary unchanged
              res_q   <= decided;
              trial_q <= decided;
              state_q <= SAB_IDLE;
            end
            else
            begin
              trial_q          <= decided;
              trial_q[bit_q-1] <= 1'b1;
              bit_q            <= bit_q - 4'h1;
            end
          end
        end
        default:
          state_q <= SAB_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conversion_busy_flag <= 1'b0;
    else if (start)
      conversion_busy_flag <= 1'b1;
    else if (state_q == SAB_CONV && bit_end && last_bit)
      conversion_busy_flag <= 1'b0;
  end
  assign dac_trial = trial_q;

  // ==========================================================
  // output groups, registered from pin state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      upper_nibble_oe   <= 1'b0;
      middle_nibble_oe  <= 1'b0;
      lower_nibble_oe   <= 1'b0;
      upper_nibble_out  <= 4'h0;
      middle_nibble_out <= 4'h0;
      lower_nibble_out  <= 4'h0;
    end
    else
    begin
      upper_nibble_out <= res_q[RW-1 -: NW];
      lower_nibble_out <= res_q[NW-1:0];
      if (word_width_sel)
      begin
        // one word read, address ignored
        upper_nibble_oe   <= rd;
        middle_nibble_oe  <= rd;
        lower_nibble_oe   <= rd;
        middle_nibble_out <= res_q[2*NW-1 -: NW];
      end
      else if (!byte_addr_short_cycle)
      begin
        upper_nibble_oe   <= rd;
        middle_nibble_oe  <= rd;
        lower_nibble_oe   <= 1'b0;
        middle_nibble_out <= res_q[2*NW-1 -: NW];
      end
      else
      begin
        upper_nibble_oe   <= 1'b0;
        middle_nibble_oe  <= rd;
        lower_nibble_oe   <= rd;
        middle_nibble_out <= 4'h0;
      end
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       aphase;
  logic [7:0] aaddr;
  logic [31:0] rd_mux;
  assign aphase = hsel && hready && (htrans[1] == sab_pkg::HTRANS_NONSEQ[1]);
  assign aaddr  = haddr[7:0];
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (aaddr == sab_pkg::ADDR_CTRL)
      rd_mux[sab_pkg::CTRL_STANDALONE_BIT] = standalone_q;
    else if (aaddr == sab_pkg::ADDR_STATUS)
    begin
      rd_mux[sab_pkg::STATUS_BUSY_BIT]  = conversion_busy_flag;
      rd_mux[sab_pkg::STATUS_SHORT_BIT] = short_q;
    end
    else if (aaddr == sab_pkg::ADDR_RESULT)
      rd_mux[RW-1:0] = res_q;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= sab_pkg::HRESP_OKAY;
    end
    else
    begin
      wr_pend_q <= aphase && hwrite;
      if (aphase)
        wr_addr_q <= aaddr;
      // read data captured at the address phase, valid in data phase
      if (aphase && !hwrite)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp     <= sab_pkg::HRESP_OKAY;
    end
  end
  // mode change is blocked mid-conversion to keep the cycle coherent
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      standalone_q <= sab_pkg::CTRL_STANDALONE_RST;
    else if (wr_pend_q && wr_addr_q == sab_pkg::ADDR_CTRL
             && state_q == SAB_IDLE)
      standalone_q <= hwdata[sab_pkg::CTRL_STANDALONE_BIT];
  end

  // ==========================================================
  // checks
  logic [15:0] busy_len_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_len_q <= 16'h0000;
    else if (start)
      busy_len_q <= 16'h0000;
    else if (conversion_busy_flag)
      busy_len_q <= busy_len_q + 16'h0001;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_byte_rd(logic a);
    rd && !word_width_sel && byte_addr_short_cycle == a;
  endsequence
  sequence s_conv_end;
    $fell(conversion_busy_flag);
  endsequence
  property p_full_len;
    s_conv_end and !short_q |-> busy_len_q == 16'(RW * BIT_CYCLES);
  endproperty
  a_full_len: assert property (p_full_len)
    else $error("full conversion length wrong");
  property p_short_len;
    s_conv_end and short_q |->
      busy_len_q == 16'(sab_pkg::SHORT_BITS * BIT_CYCLES)
      && res_q[NW-1:0] == 4'h0;
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("short conversion wrong");
  property p_byte_lo;
    s_byte_rd(1'b0) |=> upper_nibble_oe && middle_nibble_oe
      && !lower_nibble_oe
      && {upper_nibble_out, middle_nibble_out} == $past(res_q[RW-1:NW]);
  endproperty
  a_byte_lo: assert property (p_byte_lo)
    else $error("byte read, address low, wrong");
  property p_byte_hi;
    s_byte_rd(1'b1) |=> !upper_nibble_oe && middle_nibble_oe
      && lower_nibble_oe && middle_nibble_out == 4'h0
      && lower_nibble_out == $past(res_q[NW-1:0]);
  endproperty
  a_byte_hi: assert property (p_byte_hi)
    else $error("byte read, address high, wrong");
  property p_unselected;
    !selected |=> !upper_nibble_oe && !middle_nibble_oe
      && !lower_nibble_oe && !$rose(conversion_busy_flag);
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("acted while not selected");
  property p_word_rd;
    rd && word_width_sel |=> upper_nibble_oe && middle_nibble_oe
      && lower_nibble_oe && {upper_nibble_out, middle_nibble_out,
      lower_nibble_out} == $past(res_q);
  endproperty
  a_word_rd: assert property (p_word_rd)
    else $error("word read wrong");
  property p_rc_high_no_start;
    !standalone_q && read_convert |=> !$rose(conversion_busy_flag);
  endproperty
  a_rc_high_no_start: assert property (p_rc_high_no_start)
    else $error("conversion started on read level");
  property p_standalone_start;
    standalone_q && selected && $fell(read_convert)
      && state_q == SAB_IDLE |=> conversion_busy_flag ##1 conversion_busy_flag;
  endproperty
  a_standalone_start: assert property (p_standalone_start)
    else $error("falling edge did not start");
  property p_busy_state;
    conversion_busy_flag == (state_q == SAB_CONV);
  endproperty
  a_busy_state: assert property (p_busy_state)
    else $error("busy flag disagrees with sequencer");
endmodule
`default_nettype wire

// ==== verification/sab_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// analog front end: input level held as a code
module sab_analog_model (
  // trial code from the converter
  input  wire logic [11:0] dac_trial,
  // held input level
  input  wire logic [11:0] analog_code,
  // comparator decision
  output logic             comp_above
);
  // ideal comparator, so a correct sequencer must return the code exactly on a full 12-bit conversion
  assign comp_above = (analog_code >= dac_trial);
endmodule
`default_nettype wire

// ==== verification/sab_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sab_ctrl_tb_top;
  // ==========================================================
  // signals
  localparam int BC = 2;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        chip_enable, chip_select_n, read_convert;
  logic        byte_addr_short_cycle, word_width_sel;
  logic [3:0]  upper_nibble_out, middle_nibble_out, lower_nibble_out;
  logic        upper_nibble_oe, middle_nibble_oe, lower_nibble_oe;
  logic        conversion_busy_flag, comp_above;
  logic [11:0] dac_trial, analog_code;
  int          miscompares, check_count, cycles;
  logic [11:0] codes [4] = '{12'hA5C, 12'h800, 12'h7FF, 12'hFFF};

  sab_ctrl #(.BIT_CYCLES(BC)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .chip_enable(chip_enable),
    .chip_select_n(chip_select_n), .read_convert(read_convert),
    .byte_addr_short_cycle(byte_addr_short_cycle),
    .word_width_sel(word_width_sel),
    .upper_nibble_out(upper_nibble_out), .upper_nibble_oe(upper_nibble_oe),
    .middle_nibble_out(middle_nibble_out),
    .middle_nibble_oe(middle_nibble_oe),
    .lower_nibble_out(lower_nibble_out), .lower_nibble_oe(lower_nibble_oe),
    .conversion_busy_flag(conversion_busy_flag),
    .dac_trial(dac_trial), .comp_above(comp_above)
  );

  sab_analog_model model_u (
    .dac_trial(dac_trial), .analog_code(analog_code),
    .comp_above(comp_above)
  );

  // ==========================================================
  // clock and timeout
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // no wait limit of its own: only the bench timeout ends a stall
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd, output logic [31:0] data);
    hsel   <= 1'b1;
    haddr  <= {24'h0, addr};
    htrans <= sab_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    data = hrdata;
    check("hresp", 32'(sab_pkg::HRESP_OKAY), 32'(hresp));
  endtask

  // one convert command, then the busy length is counted
  task automatic convert(input logic ce, input logic csn, input logic a0,
                         input int exp_len);
    int n = 0;
    int len = 0;
    chip_enable           <= ce;
    chip_select_n         <= csn;
    byte_addr_short_cycle <= a0;
    read_convert          <= 1'b0;
    @(posedge hclk);
    chip_enable   <= 1'b0;
    chip_select_n <= 1'b1;
    read_convert  <= 1'b1;
    while (conversion_busy_flag !== 1'b1 && n < 4)
    begin
      @(posedge hclk);
      n++;
    end
    // sequencer opens with only the top trial bit set
    if (exp_len != 0)
      check("first trial", 32'h800, 32'(dac_trial));
    while (conversion_busy_flag === 1'b1 && len < 200)
    begin
      @(posedge hclk);
      len++;
    end
    check("busy cycles", 32'(exp_len), 32'(len));
  endtask

  task automatic pin_read(input logic wsel, input logic a0,
                          input logic [2:0] exp_oe, input logic [11:0] exp_d);
    logic [11:0] got;
    chip_enable           <= 1'b1;
    chip_select_n         <= 1'b0;
    word_width_sel        <= wsel;
    byte_addr_short_cycle <= a0;
    repeat (3) @(posedge hclk);
    got = {upper_nibble_oe ? upper_nibble_out : 4'h0,
           middle_nibble_oe ? middle_nibble_out : 4'h0,
           lower_nibble_oe ? lower_nibble_out : 4'h0};
    check("output enables", 32'(exp_oe),
          32'({upper_nibble_oe, middle_nibble_oe, lower_nibble_oe}));
    check("result pins", 32'(exp_d), 32'(got));
    check("busy on read", 32'h0, 32'(conversion_busy_flag));
    chip_enable   <= 1'b0;
    chip_select_n <= 1'b1;
    repeat (3) @(posedge hclk);
    check("released enables", 32'h0,
          32'({upper_nibble_oe, middle_nibble_oe, lower_nibble_oe}));
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial
  begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {chip_enable, byte_addr_short_cycle, word_width_sel} = '0;
    {chip_select_n, read_convert} = 2'b11;
    analog_code = 12'h000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("busy after reset", 32'h0, 32'(conversion_busy_flag));
    ahb(1'b0, sab_pkg::ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", 32'h0, rd);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    foreach (codes[i])
    begin
      analog_code = codes[i];
      convert(1'b1, 1'b0, 1'b0, 12 * BC);
      ahb(1'b0, sab_pkg::ADDR_RESULT, 32'h0, rd);
      check("result word", 32'(codes[i]), rd);
    end
    analog_code = 12'hA5C;
    convert(1'b1, 1'b0, 1'b0, 12 * BC);
    pin_read(1'b1, 1'b0, 3'b111, 12'hA5C);
    pin_read(1'b1, 1'b1, 3'b111, 12'hA5C);
    pin_read(1'b0, 1'b0, 3'b110, 12'hA50);
    pin_read(1'b0, 1'b1, 3'b011, 12'h00C);
    // short cycle leaves the low nibble cleared
    analog_code = 12'h7FF;
    convert(1'b1, 1'b0, 1'b1, 8 * BC);
    ahb(1'b0, sab_pkg::ADDR_STATUS, 32'h0, rd);
    check("status short", 32'h2, rd);
    ahb(1'b0, sab_pkg::ADDR_RESULT, 32'h0, rd);
    check("short result", 32'h7F0, rd);
    analog_code = 12'h123;
    convert(1'b0, 1'b0, 1'b0, 0);
    convert(1'b1, 1'b1, 1'b0, 0);
    ahb(1'b0, sab_pkg::ADDR_RESULT, 32'h0, rd);
    check("result kept", 32'h7F0, rd);
    // stand-alone mode: falling edge of read/convert starts
    ahb(1'b1, sab_pkg::ADDR_CTRL, 32'h1, rd);
    analog_code = 12'h3C1;
    convert(1'b1, 1'b0, 1'b0, 12 * BC);
    ahb(1'b0, sab_pkg::ADDR_RESULT, 32'h0, rd);
    check("stand-alone result", 32'h3C1, rd);
    // a fall while unselected is no edge for a later select
    read_convert <= 1'b0;
    @(posedge hclk);
    convert(1'b1, 1'b0, 1'b0, 0);
    ahb(1'b1, sab_pkg::ADDR_CTRL, 32'h0, rd);
    print_verdict();
  end
endmodule
`default_nettype wire
